// [rtl/adc_serial_control_interface.sv]
// Overview of operation
// (R1) chip select high: serial clock and input ignored, output released
// (R2) ready output is a plain flop output, always driven
// (R3) reset pin returns every register to its default value
// (R4) shared data line unsupported for continuous read; host must avoid it
// (R5) zeros then 32 consecutive ones on serial input reset the device
// (R6) each access starts with the communications byte, then the register
// (R7) host shifts zeros in while reading data out
// (R8) mode write clears the ready bits and takes the ready pin high, except a result finishing in that same cycle
// (R9) single conversion updates data, goes idle, sets ready, pin low
// (R10) data register read clears its ready bit, pin returns high
// (R11) status-prefix bit makes data reads shift status then data
// (R12) host keeps serial input low during prefixed 24-bit reads
// (R13) continuous conversion walks enabled channels from the addressed one
// (R14) ready function: pin low on any unread, or all enabled unread
// (R15) new result overwrites; ready drops, pin high through 163-cycle scaling
// (R16) result finishing during a read of its channel is discarded
// (R17) 48h with continuous-read bit enters continuous read mode
// (R18) continuous read always sends status then data of last result
// (R19) host uses continuous conversion, ready function 0, reads in time
// (R20) serial input high at an access start leaves continuous read
// (R21) leaving continuous read keeps the mode bit; 48h re-enters
// (R22) host issues a pin or serial reset first
// (R23) single mode field returns to idle after its conversion
// (R24) single conversion ignores the channel enable bit
// (R25) standby keeps the serial interface fully usable
// (R26) msb first, whole bytes, command byte holds address and direction
`timescale 1ns/1ps
`default_nettype none
module adc_serial_control_interface (
  // system clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // serial link
  input  wire logic        sclk_in,
  input  wire logic        cs_n_in,
  input  wire logic        din_in,
  output logic             dout_out,
  output logic             dout_oe_out,
  output logic             rdy_n_out,
  // converter core
  input  wire logic [23:0] result_in,
  output logic [1:0]       conv_channel_out,
  output logic             standby_out
);
  // ==========================================================
  // state types
  typedef struct packed {
    logic [2:0]                  cs_s;
    logic [2:0]                  wr_s;
    logic [2:0]                  rd_s;
    logic [2:0]                  sr_s;
    logic [2:0]                  rg_s;
    logic                        link_rst;
    logic                        oe;
    logic                        rdy_n;
    logic                        stby;
    logic [7:0]                  mode;
    logic [7:0]                  io;
    logic [3:0][7:0]             setup;
    logic [3:0][7:0]             ctime;
    logic [3:0][23:0]            data;
    logic [3:0]                  ready;
    logic [1:0]                  last_ch;
    logic [1:0]                  cur_ch;
    adc_serial_pkg::conv_state_t cv;
    logic [11:0]                 cnt;
    logic                        scaling;
  } core_t;

  typedef struct packed {
    logic [1:0]                  rst_s;
    adc_serial_pkg::link_state_t st;
    logic [5:0]                  bitn;
    logic [5:0]                  len;
    logic [23:0]                 sh;
    logic [31:0]                 tx;
    logic [5:0]                  ones;
    logic                        dout;
    logic                        wr_t;
    logic [5:0]                  wr_addr;
    logic [7:0]                  wr_data;
    logic                        rd_t;
    logic [1:0]                  rd_ch;
    logic                        reading;
    logic                        sr_t;
  } link_t;

  core_t c_q;
  core_t c_d;
  link_t l_q;
  link_t l_d;

  // ==========================================================
  // helpers
  function automatic logic on_page(logic [5:0] a, logic [5:0] base);
    return a[5:2] == base[5:2];
  endfunction

  function automatic logic [11:0] conv_len(logic [7:0] ct);
    return 12'(adc_serial_pkg::SETTLE_CYC
           + (int'(ct) + 1) * adc_serial_pkg::SAMPLE_STEP
           + adc_serial_pkg::SCALE_CYC);
  endfunction

  function automatic logic [7:0] ch_status(logic [1:0] ch, core_t c);
    logic [7:0] s;
    s = 8'h00;
    s[adc_serial_pkg::CSTAT_CH_LO +: 3] = {1'b0, ch};
    s[adc_serial_pkg::CSTAT_RDY_BIT] = c.ready[ch];
    return s;
  endfunction

  function automatic logic [3:0] enables(core_t c);
    logic [3:0] e;
    e = 4'h0;
    for (int i = 0; i < 4; i++) begin
      e[i] = c.setup[i][adc_serial_pkg::SETUP_EN_BIT];
    end
    return e;
  endfunction

  // next enabled channel after cur; stays on cur if none
  function automatic logic [1:0] next_ch(logic [1:0] cur, logic [3:0] en);
    logic [1:0] n;
    logic [1:0] k;
    n = cur;
    for (int i = 3; i >= 1; i--) begin
      k = cur + 2'(i);
      if (en[k]) begin
        n = k;
      end
    end
    return n;
  endfunction

  function automatic logic rdy_cond(logic [3:0] r, logic [3:0] en,
                                    logic fn);
    if (fn) begin
      return (en != 4'h0) && ((r & en) == en);
    end
    return |r;
  endfunction

  // length in bits and value of a register read
  function automatic logic [37:0] read_word(logic [5:0] a, core_t c);
    logic [31:0] w;
    logic [5:0]  n;
    w = 32'h0;
    n = adc_serial_pkg::BYTE_BITS;
    if (a == adc_serial_pkg::ADDR_IO) begin
      w = {24'h0, c.io};
    end else if (a == adc_serial_pkg::ADDR_STAT) begin
      w = {28'h0, c.ready};
    end else if (on_page(a, adc_serial_pkg::ADDR_DATA)) begin
      if (c.mode[adc_serial_pkg::MODE_DUMP_BIT]) begin
        w = {ch_status(a[1:0], c), c.data[a[1:0]]}; // R11
        n = adc_serial_pkg::DUMP_BITS;
      end else begin
        w = {8'h0, c.data[a[1:0]]};
        n = adc_serial_pkg::DATA_BITS;
      end
    end else if (on_page(a, adc_serial_pkg::ADDR_CSTAT)) begin
      if (c.mode[adc_serial_pkg::MODE_DUMP_BIT]) begin
        w = {ch_status(a[1:0], c), c.data[a[1:0]]}; // R11
        n = adc_serial_pkg::DUMP_BITS;
      end else begin
        w = {24'h0, ch_status(a[1:0], c)};
      end
    end else if (on_page(a, adc_serial_pkg::ADDR_SETUP)) begin
      w = {24'h0, c.setup[a[1:0]]};
    end else if (on_page(a, adc_serial_pkg::ADDR_CTIME)) begin
      w = {24'h0, c.ctime[a[1:0]]};
    end else if (on_page(a, adc_serial_pkg::ADDR_MODE)) begin
      w = {24'h0, c.mode};
    end
    return {n, w};
  endfunction

  function automatic core_t core_clear(core_t c);
    core_t r;
    r = c;
    r.link_rst = 1'b0;
    r.rdy_n    = 1'b1;
    r.stby     = 1'b0;
    r.mode     = adc_serial_pkg::MODE_RESET;
    r.io       = adc_serial_pkg::IO_RESET;
    for (int i = 0; i < 4; i++) begin
      r.setup[i] = adc_serial_pkg::SETUP_RESET;
      r.ctime[i] = adc_serial_pkg::CTIME_RESET;
      r.data[i]  = 24'h000000;
    end
    r.ready   = 4'h0;
    r.last_ch = 2'h0;
    r.cur_ch  = 2'h0;
    r.cv      = adc_serial_pkg::CV_IDLE;
    r.cnt     = 12'h000;
    r.scaling = 1'b0;
    return r;
  endfunction

  // ==========================================================
  // link domain: runs on the host's serial clock
  // registers of the core are read here while quasi-static; a data
  // register is frozen for the read by the reading flag
  logic [7:0]  cbyte;
  logic [37:0] rw;
  logic [37:0] crw;
  logic [31:0] aligned;
  logic        last_bit;

  always_comb begin
    l_d      = l_q;
    l_d.rst_s = {l_q.rst_s[0], c_q.link_rst};
    cbyte    = {l_q.sh[6:0], din_in};
    rw       = read_word(cbyte[5:0], c_q);
    crw      = {adc_serial_pkg::DUMP_BITS,
                ch_status(c_q.last_ch, c_q), c_q.data[c_q.last_ch]}; // R18
    aligned  = 32'h0;
    last_bit = (l_q.bitn == l_q.len - 6'h01);
    if (l_q.rst_s[1]) begin
      l_d.st      = adc_serial_pkg::LK_COMM; // R3
      l_d.bitn    = 6'h00;
      l_d.len     = adc_serial_pkg::BYTE_BITS;
      l_d.sh      = 24'h000000;
      l_d.tx      = 32'h0;
      l_d.ones    = 6'h00;
      l_d.dout    = 1'b0;
      l_d.wr_t    = 1'b0;
      l_d.wr_addr = 6'h00;
      l_d.wr_data = 8'h00;
      l_d.rd_t    = 1'b0;
      l_d.rd_ch   = 2'h0;
      l_d.reading = 1'b0;
      l_d.sr_t    = 1'b0;
    end else if (!cs_n_in) begin // R1
      l_d.sh   = {l_q.sh[22:0], din_in}; // R26
      l_d.bitn = l_q.bitn + 6'h01;
      l_d.ones = din_in ? l_q.ones + 6'h01 : 6'h00;
      l_d.dout = l_q.tx[31];
      l_d.tx   = {l_q.tx[30:0], 1'b0};
      case (l_q.st)
        adc_serial_pkg::LK_COMM: begin
          if (last_bit) begin
            l_d.bitn = 6'h00;
            l_d.dout = 1'b0;
            if (cbyte == adc_serial_pkg::CREAD_CMD &&
                c_q.mode[adc_serial_pkg::MODE_CREAD_BIT]) begin
              l_d.st      = adc_serial_pkg::LK_CREAD; // R17
              l_d.len     = adc_serial_pkg::WORD_BITS;
              l_d.reading = 1'b0;
              l_d.rd_ch   = c_q.last_ch;
              aligned     = crw[31:0];
              l_d.dout    = aligned[31];
              l_d.tx      = {aligned[30:0], 1'b0};
            end else if (!cbyte[adc_serial_pkg::COMM_INVALID_BIT]) begin
              l_d.wr_addr = cbyte[5:0]; // R6
              if (cbyte[adc_serial_pkg::COMM_READ_BIT]) begin
                l_d.st      = adc_serial_pkg::LK_READ;
                l_d.len     = rw[37:32];
                l_d.rd_ch   = cbyte[1:0];
                l_d.reading = on_page(cbyte[5:0], adc_serial_pkg::ADDR_DATA)
                  || (rw[37:32] == adc_serial_pkg::DUMP_BITS);
                aligned     = rw[31:0] << (6'h20 - rw[37:32]);
                l_d.dout    = aligned[31];
                l_d.tx      = {aligned[30:0], 1'b0};
              end else begin
                l_d.st  = adc_serial_pkg::LK_WRITE;
                l_d.len = adc_serial_pkg::BYTE_BITS;
              end
            end
          end
        end
        adc_serial_pkg::LK_WRITE: begin
          if (last_bit) begin
            l_d.wr_data = cbyte;
            l_d.wr_t    = ~l_q.wr_t; // R6
            l_d.st      = adc_serial_pkg::LK_COMM;
            l_d.bitn    = 6'h00;
          end
        end
        adc_serial_pkg::LK_READ: begin
          if (last_bit) begin
            l_d.st   = adc_serial_pkg::LK_COMM;
            l_d.len  = adc_serial_pkg::BYTE_BITS;
            l_d.bitn = 6'h00;
            l_d.dout = 1'b0;
            if (l_q.reading) begin
              l_d.rd_t    = ~l_q.rd_t; // R10
              l_d.reading = 1'b0;
            end
          end
        end
        adc_serial_pkg::LK_CREAD: begin
          if (l_q.bitn == 6'h00 && din_in) begin
            // mode bit is left alone, so 48h enters again
            l_d.st      = adc_serial_pkg::LK_COMM; // R4 R20 R21
            l_d.len     = adc_serial_pkg::BYTE_BITS;
            l_d.reading = 1'b0;
            l_d.dout    = 1'b0;
            l_d.tx      = 32'h0;
          end else if (l_q.bitn == 6'h00) begin
            l_d.reading = 1'b1;
          end else if (last_bit) begin
            l_d.rd_t    = ~l_q.rd_t; // R10
            l_d.reading = 1'b0;
            l_d.bitn    = 6'h00;
            l_d.rd_ch   = c_q.last_ch;
            aligned     = crw[31:0];
            l_d.dout    = aligned[31]; // R18
            l_d.tx      = {aligned[30:0], 1'b0};
          end
        end
        default: begin
          l_d.st = adc_serial_pkg::LK_COMM;
        end
      endcase
      // a high input during a prefixed read also counts here
      if (l_q.ones == adc_serial_pkg::ONES_LAST && din_in) begin
        l_d.sr_t    = ~l_q.sr_t; // R5
        l_d.st      = adc_serial_pkg::LK_COMM;
        l_d.bitn    = 6'h00;
        l_d.len     = adc_serial_pkg::BYTE_BITS;
        l_d.ones    = 6'h00;
        l_d.dout    = 1'b0;
        l_d.tx      = 32'h0;
        l_d.reading = 1'b0;
      end
    end
  end

  always_ff @(posedge sclk_in) begin
    l_q <= l_d;
  end

  // ==========================================================
  // core domain: registers and conversion sequencing
  logic        wr_ev;
  logic        rd_ev;
  logic        sr_ev;
  logic        guard;
  logic        mode_wr;
  logic [11:0] clen;
  logic [2:0]  fld;

  always_comb begin
    c_d      = c_q;
    c_d.link_rst = 1'b0;
    c_d.cs_s = {c_q.cs_s[1:0], cs_n_in};
    c_d.wr_s = {c_q.wr_s[1:0], l_q.wr_t};
    c_d.rd_s = {c_q.rd_s[1:0], l_q.rd_t};
    c_d.sr_s = {c_q.sr_s[1:0], l_q.sr_t};
    c_d.rg_s = {c_q.rg_s[1:0], l_q.reading};
    wr_ev    = c_q.wr_s[2] ^ c_q.wr_s[1];
    rd_ev    = c_q.rd_s[2] ^ c_q.rd_s[1];
    sr_ev    = c_q.sr_s[2] ^ c_q.sr_s[1];
    // either late stage counts: the guard errs toward holding off
    guard    = (c_q.rg_s[2] | c_q.rg_s[1]) && (l_q.rd_ch == c_q.cur_ch);
    mode_wr  = wr_ev && on_page(l_q.wr_addr, adc_serial_pkg::ADDR_MODE);
    clen     = conv_len(c_q.ctime[c_q.cur_ch]);
    fld      = l_q.wr_data[adc_serial_pkg::MODE_FIELD_LO +: 3];
    if (c_q.cs_s[2] == c_q.cs_s[1]) begin
      c_d.oe = ~c_q.cs_s[1]; // R1
    end
    if (rd_ev) begin
      c_d.ready[l_q.rd_ch] = 1'b0; // R10
    end
    if (wr_ev) begin
      if (l_q.wr_addr == adc_serial_pkg::ADDR_IO) begin
        c_d.io = l_q.wr_data;
      end else if (on_page(l_q.wr_addr, adc_serial_pkg::ADDR_SETUP)) begin
        c_d.setup[l_q.wr_addr[1:0]] = l_q.wr_data;
      end else if (on_page(l_q.wr_addr, adc_serial_pkg::ADDR_CTIME)) begin
        c_d.ctime[l_q.wr_addr[1:0]] = l_q.wr_data;
      end else if (mode_wr) begin
        c_d.mode    = l_q.wr_data;
        c_d.ready   = 4'h0; // R8
        c_d.scaling = 1'b0;
        c_d.cnt     = 12'h000;
        c_d.cur_ch  = l_q.wr_addr[1:0]; // R24
        c_d.stby    = (fld == adc_serial_pkg::MODE_STANDBY); // R25
        if (fld == adc_serial_pkg::MODE_SINGLE ||
            fld == adc_serial_pkg::MODE_CONT) begin
          c_d.cv = adc_serial_pkg::CV_RUN; // R9 R13
        end else begin
          c_d.cv = adc_serial_pkg::CV_IDLE;
        end
      end
    end
    case (c_q.cv)
      adc_serial_pkg::CV_RUN: begin
        if (!mode_wr) begin
          c_d.cnt = c_q.cnt + 12'h001;
        end
        if (c_q.cnt == clen - 12'(adc_serial_pkg::SCALE_CYC + 1) && !mode_wr)
        begin
          c_d.scaling = 1'b1; // R15
          c_d.ready[c_q.cur_ch] = 1'b0; // R15
        end
        if (c_q.cnt == clen - 12'h001) begin
          // a result finishing under a read of its channel is lost
          if (!guard) begin
            c_d.data[c_q.cur_ch]  = result_in; // R15 R16
            c_d.ready[c_q.cur_ch] = 1'b1; // R9
            c_d.last_ch           = c_q.cur_ch;
          end
          if (!mode_wr) begin
            c_d.scaling = 1'b0;
            c_d.cnt     = 12'h000;
            if (c_q.mode[adc_serial_pkg::MODE_FIELD_LO +: 3] ==
                adc_serial_pkg::MODE_CONT) begin
              c_d.cur_ch = next_ch(c_q.cur_ch, enables(c_q)); // R13
            end else begin
              c_d.mode[adc_serial_pkg::MODE_FIELD_LO +: 3] =
                adc_serial_pkg::MODE_IDLE; // R23
              c_d.cv = adc_serial_pkg::CV_IDLE; // R9
            end
          end
        end
      end
      adc_serial_pkg::CV_IDLE: begin
        c_d.scaling = 1'b0;
      end
      default: begin
        c_d.cv = adc_serial_pkg::CV_IDLE;
      end
    endcase
    c_d.rdy_n = c_d.scaling | ~rdy_cond(c_d.ready, enables(c_d),
                  c_d.io[adc_serial_pkg::IO_READY_PIN_FUNCTION_BIT]); // R14 R15
    if (sr_ev) begin
      c_d = core_clear(c_d); // R5
    end
    if (!rst_n_in) begin
      c_d          = core_clear(core_t'(0)); // R3
      c_d.link_rst = 1'b1;
      // idle select level, so no false enable follows reset
      c_d.cs_s     = 3'h7;
    end
  end

  always_ff @(posedge clk_in) begin
    c_q <= c_d;
  end

  // ==========================================================
  // outputs
  assign dout_out         = l_q.dout;
  assign dout_oe_out      = c_q.oe;
  assign rdy_n_out        = c_q.rdy_n; // R2
  assign conv_channel_out = c_q.cur_ch;
  assign standby_out      = c_q.stby;
endmodule
`default_nettype wire

// [rtl/adc_serial_pkg.sv]
package adc_serial_pkg;
  // ==========================================================
  // register addresses (6-bit space; IO and status one address each, the others pages of four)
  localparam logic [5:0] ADDR_IO    = 6'h01;
  localparam logic [5:0] ADDR_STAT  = 6'h04;
  localparam logic [5:0] ADDR_DATA  = 6'h08;
  localparam logic [5:0] ADDR_CSTAT = 6'h20;
  localparam logic [5:0] ADDR_SETUP = 6'h28;
  localparam logic [5:0] ADDR_CTIME = 6'h30;
  localparam logic [5:0] ADDR_MODE  = 6'h38;
  // ==========================================================
  // communications byte
  localparam int         COMM_INVALID_BIT = 7;
  localparam int         COMM_READ_BIT    = 6;
  localparam logic [7:0] CREAD_CMD        = 8'h48;
  // ==========================================================
  // fields
  localparam int         MODE_FIELD_LO    = 5;
  localparam int         MODE_DUMP_BIT    = 3;
  localparam int         MODE_CREAD_BIT   = 2;
  localparam int         IO_READY_PIN_FUNCTION_BIT     = 3;
  localparam int         SETUP_EN_BIT     = 0;
  localparam int         CSTAT_CH_LO      = 5;
  localparam int         CSTAT_RDY_BIT    = 3;
  localparam logic [2:0] MODE_IDLE        = 3'h0;
  localparam logic [2:0] MODE_CONT        = 3'h1;
  localparam logic [2:0] MODE_SINGLE      = 3'h2;
  localparam logic [2:0] MODE_STANDBY     = 3'h3;
  // ==========================================================
  // reset values
  localparam logic [7:0] MODE_RESET       = 8'h00;
  localparam logic [7:0] IO_RESET         = 8'h00;
  localparam logic [7:0] SETUP_RESET      = 8'h01;
  localparam logic [7:0] CTIME_RESET      = 8'h10;
  // ==========================================================
  // widths in bits, timing in master clock cycles
  localparam logic [5:0] BYTE_BITS        = 6'h08;
  localparam logic [5:0] DATA_BITS        = 6'h18;
  localparam logic [5:0] DUMP_BITS        = 6'h20;
  localparam logic [5:0] WORD_BITS        = 6'h20;
  localparam logic [5:0] ONES_LAST        = 6'h1F;
  localparam int         SETTLE_CYC       = 43;
  localparam int         SAMPLE_STEP      = 8;
  localparam int         SCALE_CYC        = 163;
  // ==========================================================
  typedef enum logic [3:0] {
    LK_COMM  = 4'h1,
    LK_WRITE = 4'h2,
    LK_READ  = 4'h4,
    LK_CREAD = 4'h8
  } link_state_t;
  typedef enum logic [1:0] {
    CV_IDLE = 2'h1,
    CV_RUN  = 2'h2
  } conv_state_t;
endpackage

// [tb/adc_serial_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_serial_properties (
  // watched ports
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        sclk_in,
  input wire logic        cs_n_in,
  input wire logic        din_in,
  input wire logic        dout_out,
  input wire logic        dout_oe_out,
  input wire logic        rdy_n_out,
  input wire logic [23:0] result_in,
  input wire logic [1:0]  conv_channel_out,
  input wire logic        standby_out
);
  // ==========
  // run length of a high ready pin, saturating
  logic [8:0] hi_q;
  always_ff @(posedge clk_in)
    if (!rst_n_in || !rdy_n_out) hi_q <= 9'h000;
    else if (hi_q != 9'h1FF) hi_q <= hi_q + 9'h001;
  // ==========
  // assertions
  chk_oe_released: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) cs_n_in [*5] |-> !dout_oe_out)
    else $error("dout enabled while deselected");
  chk_oe_driving: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) !cs_n_in [*5] |-> dout_oe_out)
    else $error("dout not enabled while selected");
  chk_oe_lag: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) cs_n_in [*5] ##1 !cs_n_in |-> !dout_oe_out)
    else $error("dout enabled before select settled");
  chk_dout_frozen: assert property (@(posedge sclk_in)
    disable iff (!rst_n_in) cs_n_in |=> $stable(dout_out))
    else $error("dout moved on a deselected clock");
  chk_reset_state: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) $rose(rst_n_in) |-> rdy_n_out && !dout_oe_out
      && !standby_out && conv_channel_out == 2'h0)
    else $error("outputs not at default after reset");
  chk_scale_high: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) $fell(rdy_n_out) |-> hi_q >= 9'h0A3)
    else $error("ready pin high for fewer than 163 cycles");
  chk_rise_holds: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) $rose(rdy_n_out) |-> rdy_n_out [*8])
    else $error("ready pin fell too soon after rising");
  chk_standby_quiet: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) standby_out |-> !$fell(rdy_n_out))
    else $error("result appeared in standby");
  // ==========
  // main scenarios reached
  cov_result: cover property (@(posedge clk_in) $fell(rdy_n_out));
  cov_standby: cover property (@(posedge clk_in) $rose(standby_out));
  cov_select: cover property (@(posedge clk_in) !cs_n_in [*5]);
endmodule
bind adc_serial_control_interface adc_serial_properties chk_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk_in),
  .cs_n_in(cs_n_in), .din_in(din_in), .dout_out(dout_out),
  .dout_oe_out(dout_oe_out), .rdy_n_out(rdy_n_out),
  .result_in(result_in), .conv_channel_out(conv_channel_out),
  .standby_out(standby_out));
`default_nettype wire

// [tb/host_port.sv]
`timescale 1ns/1ps
`default_nettype none
module host_port (
  // serial pins toward the device
  output var logic  sclk_out,
  output var logic  cs_n_out,
  output var logic  din_out,
  input  wire logic dout_in,
  input  wire logic dout_oe_in
);
  // ==========
  // released line reads inverted so a stale bit never passes
  wire logic miso = dout_oe_in ? dout_in : ~dout_in;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out  = 1'b0;
  end
  // ==========
  // link clock pulses outside frames, select left high
  task automatic pulses(input int n);
    repeat (n) begin
      #3 sclk_out = 1'b1;
      #3 sclk_out = 1'b0;
    end
  endtask
  task automatic frame(input int n, input logic [39:0] tx,
                       output logic [39:0] rx);
    rx = 40'h0;
    cs_n_out <= 1'b0;
    #260 din_out <= tx[n-1];
    for (int i = n - 1; i >= 0; i--) begin
      #3 sclk_out = 1'b1;
      rx[i] = miso;
      if (i > 0) din_out <= tx[i-1];
      #3 sclk_out = 1'b0;
    end
    #3 cs_n_out <= 1'b1;
    din_out <= ~din_out;
    #450;
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========
  // signals
  logic        clk_in;
  logic        rst_n_in;
  logic [23:0] result_in;
  logic        sclk;
  logic        cs_n;
  logic        din;
  logic        dout;
  logic        dout_oe;
  logic        rdy_n;
  logic        standby;
  logic [1:0]  conv_ch;
  logic [31:0] rnd;
  logic [39:0] rx;
  logic [23:0] val;
  logic [1:0]  ch;
  int          n_errors;
  int          cmp_count;
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  adc_serial_control_interface uut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .din_in(din), .dout_out(dout),
    .dout_oe_out(dout_oe), .rdy_n_out(rdy_n), .result_in(result_in),
    .conv_channel_out(conv_ch), .standby_out(standby));
  host_port host (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
    .dout_in(dout), .dout_oe_in(dout_oe));
  // ==========
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] stat_exp(input logic [1:0] c,
                                          input logic r);
    return {1'b0, c, 1'b0, r, 3'h0};
  endfunction
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.frame(16, {24'h0, 2'b00, a, d}, rx);
  endtask
  // zeros go out while the answer comes back
  task automatic rd(input logic [5:0] a, input int n);
    host.frame(8 + n, {2'b01, a, 32'h0} >> (32 - n), rx);
  endtask
  task automatic wait_rdy();
    int i;
    for (i = 0; i < 2000 && rdy_n !== 1'b0; i++) @(posedge clk_in);
    if (i == 2000) begin
      check("rdy_n", 32'(rdy_n), 32'h0);
      report_and_stop();
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    rnd = 32'hF9BBA81C;
    n_errors = 0;
    cmp_count = 0;
    rst_n_in = 1'b0;
    result_in = 24'h000000;
    repeat (2) @(posedge clk_in);
    host.pulses(4);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    host.pulses(3);
    check("rdy_n", 32'(rdy_n), 32'h1);
    check("dout_oe", 32'(dout_oe), 32'h0);
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      wr(adc_serial_pkg::ADDR_SETUP + 6'(k), rnd[7:0]);
      rd(adc_serial_pkg::ADDR_SETUP + 6'(k), 8);
      check("setup", 32'(rx[7:0]), 32'(rnd[7:0]));
    end
    rd(6'h02, 8);
    check("unmapped", 32'(rx[7:0]), 32'h0);
    wr(adc_serial_pkg::ADDR_IO, 8'h08);
    host.frame(40, {8'h00, 32'hFFFFFFFF}, rx);
    rd(adc_serial_pkg::ADDR_IO, 8);
    check("io", 32'(rx[7:0]), 32'(adc_serial_pkg::IO_RESET));
    rd(adc_serial_pkg::ADDR_SETUP, 8);
    check("setup", 32'(rx[7:0]), 32'(adc_serial_pkg::SETUP_RESET));
    // single conversion on a disabled channel, shortest conversion time
    rnd = lfsr(rnd);
    ch = rnd[1:0];
    val = rnd[31:8];
    @(posedge clk_in);
    result_in <= val;
    wr(adc_serial_pkg::ADDR_SETUP + 6'(ch), 8'h00);
    wr(adc_serial_pkg::ADDR_CTIME + 6'(ch), 8'h00);
    wr(adc_serial_pkg::ADDR_MODE + 6'(ch), 8'h48);
    wait_rdy();
    check("conv_ch", 32'(conv_ch), 32'(ch));
    rd(adc_serial_pkg::ADDR_MODE + 6'(ch), 8);
    check("mode", 32'(rx[7:0]), 32'h08);
    wr(adc_serial_pkg::ADDR_MODE + 6'(ch), 8'h48);
    check("rdy_n", 32'(rdy_n), 32'h1);
    wait_rdy();
    rd(adc_serial_pkg::ADDR_DATA + 6'(ch), 32);
    check("dump", rx[31:0] & 32'hE8FFFFFF, {stat_exp(ch, 1'b1), val});
    check("rdy_n", 32'(rdy_n), 32'h1);
    rd(adc_serial_pkg::ADDR_CSTAT + 6'(ch), 32);
    check("dump", rx[31:0] & 32'hE8FFFFFF, {stat_exp(ch, 1'b0), val});
    // standby keeps registers reachable
    wr(adc_serial_pkg::ADDR_MODE, 8'h60);
    check("standby", 32'(standby), 32'h1);
    rnd = lfsr(rnd);
    wr(adc_serial_pkg::ADDR_CTIME + 6'h02, rnd[7:0]);
    rd(adc_serial_pkg::ADDR_CTIME + 6'h02, 8);
    check("ctime", 32'(rx[7:0]), 32'(rnd[7:0]));
    wr(adc_serial_pkg::ADDR_MODE, 8'h00);
    // continuous over channels 0 and 1, pin waits for both
    for (int k = 0; k < 4; k++) begin
      wr(adc_serial_pkg::ADDR_SETUP + 6'(k), 8'(k < 2));
      wr(adc_serial_pkg::ADDR_CTIME + 6'(k), 8'h00);
    end
    wr(adc_serial_pkg::ADDR_IO, 8'h08);
    wr(adc_serial_pkg::ADDR_MODE + 6'h01, 8'h20);
    wait_rdy();
    rd(adc_serial_pkg::ADDR_STAT, 8);
    check("all_ready", 32'(rx[3:0]), 32'h3);
    rnd = lfsr(rnd);
    @(posedge clk_in);
    result_in <= rnd[31:8];
    repeat (500) @(posedge clk_in);
    rd(adc_serial_pkg::ADDR_DATA, 24);
    check("overwrite", 32'(rx[23:0]), 32'(rnd[31:8]));
    wr(adc_serial_pkg::ADDR_IO, 8'h00);
    wr(adc_serial_pkg::ADDR_MODE, 8'h24);
    repeat (2) begin
      host.frame(8, 40'h48, rx);
      for (int k = 0; k < 2; k++) begin
        wait_rdy();
        host.frame(32, 40'h0, rx);
        check("cread_ch", 32'(rx[31:30]), 32'h0);
        check("cread", 32'(rx[23:0]), 32'(rnd[31:8]));
      end
      host.frame(8, 40'h80, rx);
      rd(adc_serial_pkg::ADDR_MODE, 8);
      check("mode", 32'(rx[7:0]), 32'h24);
    end
    wr(adc_serial_pkg::ADDR_MODE, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
